// ---- tws_slave_transmitter.sv ----
`timescale 1ns/1ps
`default_nettype none
module tws_slave_transmitter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic arbitration_lost,
    output logic start_pending,
    output logic wake_up
);
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_prev;
        logic sda_prev;
        logic wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        logic [7:0] own_slave_address;
        logic [7:0] control;
        logic [7:0] status;
        logic [7:0] shift_data;
        logic sleep_mode;
        tws_pkg::tws_state_t st;
        logic [7:0] shreg;
        logic [3:0] bitcnt;
        logic last_byte;
        logic arb_lost_seen;
        logic bus_busy;
        logic start_pending;
        logic scl_hold;
        logic sda_drive;
        logic wake_up;
        logic ready_out;
        logic resp_out;
        logic scl_level;
        logic sda_level;
    } tws_regs_t;

    // Both bus lines are open drain: the block only ever pulls low, so the pin
    // levels are held at zero and the enables alone decide what the bus sees.
    // The bus pins come from another domain and pass two flip-flops before use.
    // This costs two clocks of latency on every edge, which the bus timing
    // leaves ample room for at this clock rate.
    // Start requests are only remembered here; the master side that would put
    // the start condition on the bus is not part of this block.

    tws_regs_t r;
    tws_regs_t next_r;

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic addr_hit;
    logic rd_phase;
    logic flag_clear_wr;

    assign scl_s = r.scl_sync[1];
    assign sda_s = r.sda_sync[1];
    assign scl_rise = scl_s && !r.scl_prev;
    assign scl_fall = !scl_s && r.scl_prev;
    assign start_cond = scl_s && r.scl_prev && r.sda_prev && !sda_s;
    assign stop_cond = scl_s && r.scl_prev && !r.sda_prev && sda_s;
    // Read data is prepared in the address phase so it stands in the data phase.
    assign rd_phase = hsel && hready && htrans[1] && !hwrite;
    // A clear takes effect in the write's data phase, together with the register update.
    assign flag_clear_wr = r.wr_pend && (r.wr_addr == tws_pkg::ADDR_TWO_WIRE_CONTROL)
        && hwdata[tws_pkg::CTL_COMPLETION_FLAG];

    always_comb begin
        next_r = r;
        next_r.scl_sync = {r.scl_sync[0], scl_in};
        next_r.sda_sync = {r.sda_sync[0], sda_in};
        next_r.scl_prev = scl_s;
        next_r.sda_prev = sda_s;
        // Address match is only meaningful at the falling edge after the eighth bit.
        addr_hit = 1'b0;

        // Register writes land in the cycle after the address phase.
        next_r.wr_pend = hsel && hready && htrans[1] && hwrite;
        next_r.wr_addr = haddr[11:0];
        if (r.wr_pend) begin
            unique case (r.wr_addr)
                tws_pkg::ADDR_OWN_SLAVE_ADDRESS: next_r.own_slave_address = hwdata[7:0];
                tws_pkg::ADDR_TWO_WIRE_CONTROL: begin
                    next_r.control = (r.control & ~tws_pkg::CTL_WRITE_MASK)
                        | (hwdata[7:0] & tws_pkg::CTL_WRITE_MASK);
                    if (hwdata[tws_pkg::CTL_COMPLETION_FLAG]) begin
                        next_r.control[tws_pkg::CTL_COMPLETION_FLAG] = 1'b0;
                    end
                end
                tws_pkg::ADDR_SHIFT_DATA: begin
                    if (r.control[tws_pkg::CTL_COMPLETION_FLAG]) begin
                        next_r.shift_data = hwdata[7:0];
                    end else begin
                        // Writing data while the bus owns the register is a collision.
                        next_r.control[tws_pkg::CTL_WRITE_COLLISION] = 1'b1;
                    end
                end
                tws_pkg::ADDR_SLEEP_CONTROL: next_r.sleep_mode = hwdata[0];
                default: ;
            endcase
        end
        if (r.wr_pend && r.wr_addr == tws_pkg::ADDR_SHIFT_DATA
            && r.control[tws_pkg::CTL_COMPLETION_FLAG]) begin
            next_r.control[tws_pkg::CTL_WRITE_COLLISION] = 1'b0;
        end

        if (arbitration_lost) begin
            next_r.arb_lost_seen = 1'b1;
        end

        // Bus-free tracking lets a requested start wait for a stop.
        if (start_cond) begin
            next_r.bus_busy = 1'b1;
        end else if (stop_cond) begin
            next_r.bus_busy = 1'b0;
        end
        if (r.start_pending && !r.bus_busy) begin
            next_r.start_pending = 1'b0;
        end

        if (flag_clear_wr) begin
            next_r.scl_hold = 1'b0;
            next_r.wake_up = 1'b0;
            next_r.status = tws_pkg::ST_NO_INFO;
        end

        if (!r.control[tws_pkg::CTL_INTERFACE_ENABLE]) begin
            next_r.st = tws_pkg::TWS_IDLE;
            next_r.sda_drive = 1'b0;
            next_r.scl_hold = 1'b0;
            // Turning the unit off forgets any half-received frame.
            next_r.bitcnt = 4'd0;
            next_r.last_byte = 1'b0;
            next_r.arb_lost_seen = 1'b0;
        end else if ((start_cond || stop_cond) && (r.st == tws_pkg::TWS_ADDR
            || r.st == tws_pkg::TWS_ADDR_ACK
            || r.st == tws_pkg::TWS_TX_BIT || r.st == tws_pkg::TWS_RX_ACK)
            && r.bitcnt != 4'd0) begin
            // A start or stop mid-frame is a bus error.
            next_r.status = tws_pkg::ST_BUS_ERROR;
            next_r.control[tws_pkg::CTL_COMPLETION_FLAG] = 1'b1;
            next_r.st = tws_pkg::TWS_WAIT_SW;
            next_r.sda_drive = 1'b0;
        end else if (start_cond) begin
            next_r.st = tws_pkg::TWS_ADDR;
            next_r.bitcnt = 4'd0;
            next_r.sda_drive = 1'b0;
        end else if (stop_cond) begin
            next_r.st = tws_pkg::TWS_IDLE;
            next_r.sda_drive = 1'b0;
        end else begin
            unique case (r.st)
                tws_pkg::TWS_IDLE, tws_pkg::TWS_IGNORE: begin
                    next_r.sda_drive = 1'b0;
                end

                tws_pkg::TWS_ADDR: begin
                    if (scl_rise) begin
                        next_r.shreg = {r.shreg[6:0], sda_s};
                        next_r.bitcnt = r.bitcnt + 4'd1;
                    end
                    if (scl_fall && r.bitcnt == 4'd8) begin
                        addr_hit = (r.shreg[7:1] == r.own_slave_address[7:1])
                            || (r.shreg[7:1] == tws_pkg::GENERAL_CALL_ADDRESS[6:0]
                            && r.own_slave_address[0]);
                        if (addr_hit && r.control[tws_pkg::CTL_ACKNOWLEDGE_ENABLE]) begin
                            next_r.sda_drive = 1'b1;
                            next_r.st = tws_pkg::TWS_ADDR_ACK;
                            next_r.wake_up = r.sleep_mode;
                        end else begin
                            next_r.st = tws_pkg::TWS_IGNORE;
                        end
                    end
                end

                tws_pkg::TWS_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_r.sda_drive = 1'b0;
                        next_r.control[tws_pkg::CTL_COMPLETION_FLAG] = 1'b1;
                        next_r.scl_hold = 1'b1;
                        next_r.bitcnt = 4'd0;
                        if (r.shreg[0]) begin
                            next_r.status = r.arb_lost_seen ? tws_pkg::ST_ARB_LOST_READ
                                : tws_pkg::ST_OWN_READ_ACKED;
                            next_r.st = tws_pkg::TWS_WAIT_SW;
                        end else begin
                            // Receive side is outside this block; report and stand back.
                            next_r.status = (r.shreg[7:1] == tws_pkg::GENERAL_CALL_ADDRESS[6:0])
                                ? tws_pkg::ST_SR_GENERAL_CALL : tws_pkg::ST_SR_OWN_WRITE;
                            next_r.st = tws_pkg::TWS_IGNORE;
                        end
                        next_r.arb_lost_seen = 1'b0;
                        if (r.sleep_mode) begin
                            // Data register content is not kept across sleep.
                            next_r.shift_data = tws_pkg::RST_SHIFT_DATA;
                        end
                    end
                end

                tws_pkg::TWS_WAIT_SW: begin
                    // After a data byte the acknowledge rise moved us here, so the stretch begins on the
                    // following fall, once the master has let go; the address path sets it on entry.
                    if (scl_fall && r.control[tws_pkg::CTL_COMPLETION_FLAG] && !flag_clear_wr
                        && r.status != tws_pkg::ST_BUS_ERROR) begin
                        next_r.scl_hold = 1'b1;
                    end
                    if (flag_clear_wr) begin
                        if (r.status == tws_pkg::ST_BUS_ERROR) begin
                            next_r.control[tws_pkg::CTL_STOP_REQUEST] = 1'b0;
                            next_r.st = tws_pkg::TWS_IDLE;
                            // Recovery lets both lines go without sending a stop condition.
                            next_r.sda_drive = 1'b0;
                            next_r.scl_hold = 1'b0;
                        end else if (r.status == tws_pkg::ST_DATA_NACKED
                            || r.status == tws_pkg::ST_LAST_ACKED) begin
                            next_r.st = tws_pkg::TWS_IGNORE;
                            next_r.start_pending = hwdata[tws_pkg::CTL_START_REQUEST];
                        end else begin
                            // The first bit goes out at once, since the clock is held low here.
                            next_r.shreg = r.shift_data;
                            next_r.last_byte = !hwdata[tws_pkg::CTL_ACKNOWLEDGE_ENABLE];
                            next_r.sda_drive = !r.shift_data[7];
                            next_r.bitcnt = 4'd1;
                            next_r.st = tws_pkg::TWS_TX_BIT;
                        end
                    end
                end

                tws_pkg::TWS_TX_BIT: begin
                    // Later bits change only after a falling clock, never while it is high.
                    if (scl_fall) begin
                        if (r.bitcnt == 4'd8) begin
                            next_r.sda_drive = 1'b0;
                            next_r.st = tws_pkg::TWS_RX_ACK;
                        end else begin
                            next_r.sda_drive = !r.shreg[7 - r.bitcnt[2:0]];
                            next_r.bitcnt = r.bitcnt + 4'd1;
                        end
                    end
                end

                tws_pkg::TWS_RX_ACK: begin
                    // The master's answer is read on the ninth rising clock.
                    if (scl_rise) begin
                        next_r.control[tws_pkg::CTL_COMPLETION_FLAG] = 1'b1;
                        next_r.bitcnt = 4'd0;
                        if (sda_s) begin
                            next_r.status = tws_pkg::ST_DATA_NACKED;
                        end else if (r.last_byte) begin
                            next_r.status = tws_pkg::ST_LAST_ACKED;
                        end else begin
                            next_r.status = tws_pkg::ST_DATA_ACKED;
                        end
                        // Every outcome waits for software; the final byte is told apart
                        // by its status, and leaving C0 or C8 goes to the ignore state.
                        next_r.st = tws_pkg::TWS_WAIT_SW;
                    end
                end

                default: next_r.st = tws_pkg::TWS_IDLE;
            endcase
        end

        // Read data for the following data phase.
        // Unmapped offsets read as zero and their writes are dropped.
        next_r.rdata = 32'h0000_0000;
        if (rd_phase) begin
            unique case (haddr[11:0])
                tws_pkg::ADDR_OWN_SLAVE_ADDRESS: next_r.rdata[7:0] = r.own_slave_address;
                tws_pkg::ADDR_TWO_WIRE_CONTROL: next_r.rdata[7:0] = r.control;
                tws_pkg::ADDR_BUS_STATUS: next_r.rdata[7:0] = r.status;
                tws_pkg::ADDR_SHIFT_DATA: next_r.rdata[7:0] = r.shift_data;
                tws_pkg::ADDR_SLEEP_CONTROL: next_r.rdata[0] = r.sleep_mode;
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Every field is named so that none can slip out of reset unnoticed.
            r.wr_pend <= 1'b0;
            r.wr_addr <= 12'h000;
            r.rdata <= 32'h0000_0000;
            r.sleep_mode <= 1'b0;
            r.shreg <= 8'h00;
            r.bitcnt <= 4'h0;
            r.last_byte <= 1'b0;
            r.arb_lost_seen <= 1'b0;
            r.bus_busy <= 1'b0;
            r.start_pending <= 1'b0;
            r.scl_hold <= 1'b0;
            r.sda_drive <= 1'b0;
            r.wake_up <= 1'b0;
            r.ready_out <= 1'b1;
            r.resp_out <= 1'b0;
            r.scl_level <= 1'b0;
            r.sda_level <= 1'b0;
            r.scl_sync <= 2'b11;
            r.sda_sync <= 2'b11;
            r.scl_prev <= 1'b1;
            r.sda_prev <= 1'b1;
            r.own_slave_address <= tws_pkg::RST_OWN_SLAVE_ADDRESS;
            r.control <= tws_pkg::RST_CONTROL;
            r.status <= tws_pkg::ST_NO_INFO;
            r.shift_data <= tws_pkg::RST_SHIFT_DATA;
            r.st <= tws_pkg::TWS_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign hrdata = r.rdata;
    assign hreadyout = r.ready_out;
    assign hresp = r.resp_out;
    assign scl_out = r.scl_level;
    assign scl_oe = r.scl_hold;
    assign sda_out = r.sda_level;
    assign sda_oe = r.sda_drive;
    assign start_pending = r.start_pending;
    assign wake_up = r.wake_up;
endmodule
`default_nettype wire

// ---- tws_pkg.sv ----
package tws_pkg;
    // Register byte addresses on the bus.
    localparam logic [11:0] ADDR_OWN_SLAVE_ADDRESS = 12'h000;
    localparam logic [11:0] ADDR_TWO_WIRE_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_BUS_STATUS = 12'h008;
    localparam logic [11:0] ADDR_SHIFT_DATA = 12'h00C;
    localparam logic [11:0] ADDR_SLEEP_CONTROL = 12'h010;

    // Control register field positions.
    localparam int CTL_COMPLETION_FLAG = 7;
    localparam int CTL_ACKNOWLEDGE_ENABLE = 6;
    localparam int CTL_START_REQUEST = 5;
    localparam int CTL_STOP_REQUEST = 4;
    localparam int CTL_WRITE_COLLISION = 3;
    localparam int CTL_INTERFACE_ENABLE = 2;
    localparam int CTL_INTERRUPT_ENABLE = 0;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h75;

    // Reset values.
    localparam logic [7:0] RST_OWN_SLAVE_ADDRESS = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_SHIFT_DATA = 8'hFF;

    // Status codes; the low three bits of every code are zero.
    localparam logic [7:0] ST_BUS_ERROR = 8'h00;
    localparam logic [7:0] ST_SR_OWN_WRITE = 8'h60;
    localparam logic [7:0] ST_SR_GENERAL_CALL = 8'h70;
    localparam logic [7:0] ST_OWN_READ_ACKED = 8'hA8;
    localparam logic [7:0] ST_ARB_LOST_READ = 8'hB0;
    localparam logic [7:0] ST_DATA_ACKED = 8'hB8;
    localparam logic [7:0] ST_DATA_NACKED = 8'hC0;
    localparam logic [7:0] ST_LAST_ACKED = 8'hC8;
    localparam logic [7:0] ST_NO_INFO = 8'hF8;
    localparam logic [7:0] GENERAL_CALL_ADDRESS = 8'h00;

    typedef enum logic [2:0] {
        TWS_IDLE, TWS_ADDR, TWS_ADDR_ACK, TWS_WAIT_SW, TWS_TX_BIT, TWS_RX_ACK, TWS_IGNORE
    } tws_state_t;
endpackage

// ---- tws_slave_transmitter_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module tws_slave_transmitter_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic scl_in,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic start_pending,
    input wire logic wake_up
);
    logic rd_dp;
    logic wr_dp;
    logic [11:0] dp_addr;
    logic flag_wr;
    logic sreq_wr;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_dp <= 1'b0;
            wr_dp <= 1'b0;
            dp_addr <= 12'h000;
        end else begin
            rd_dp <= hsel && hready && htrans[1] && !hwrite;
            wr_dp <= hsel && hready && htrans[1] && hwrite;
            dp_addr <= haddr[11:0];
        end
    end
    // Write data only stands in the data phase, so the control write is decoded there.
    assign flag_wr = wr_dp && dp_addr == tws_pkg::ADDR_TWO_WIRE_CONTROL && hwdata[7];
    assign sreq_wr = wr_dp && dp_addr == tws_pkg::ADDR_TWO_WIRE_CONTROL && hwdata[5];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait state inserted");
    property p_idle_data; !rd_dp |-> hrdata == 32'h0000_0000; endproperty
    a_idle_data: assert property (p_idle_data) else $error("read data outside data phase");
    property p_no_info; rd_dp && dp_addr == tws_pkg::ADDR_BUS_STATUS && !scl_oe
        && !$past(scl_oe) && !$past(scl_oe, 2) |-> hrdata[7:3] == 5'h1F; endproperty
    a_no_info: assert property (p_no_info) else $error("idle status wrong");
    property p_release; flag_wr |-> ##[1:2] !scl_oe; endproperty
    a_release: assert property (p_release) else $error("clock not released");
    property p_hold; scl_oe && !flag_wr && !$past(flag_wr) |=> scl_oe; endproperty
    a_hold: assert property (p_hold) else $error("clock stretch dropped");
    property p_start; $rose(start_pending) |-> $past(sreq_wr) || $past(sreq_wr, 2); endproperty
    a_start: assert property (p_start) else $error("start request without write");
    property p_wake; $fell(wake_up) |-> $past(flag_wr) || $past(flag_wr, 2); endproperty
    a_wake: assert property (p_wake) else $error("wake ended without flag clear");
    property p_sda_edge; $changed(sda_oe) |-> !scl_in; endproperty
    a_sda_edge: assert property (p_sda_edge) else $error("data moved with clock high");
endmodule
`default_nettype wire

// ---- tws_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
    input wire logic hclk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_m,
    output logic sda_m
);
    localparam int HALF = 10;
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic hw();
        repeat (HALF) @(posedge hclk);
    endtask
    // A released line reads high through the pull-up, never the last driven value.
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b;
        hw();
        scl_m <= 1'b1;
        wait (scl === 1'b1);
        hw();
        r = sda;
        scl_m <= 1'b0;
        hw();
    endtask
    task automatic start();
        sda_m <= 1'b1;
        scl_m <= 1'b1;
        hw();
        sda_m <= 1'b0;
        hw();
        scl_m <= 1'b0;
        hw();
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        hw();
        scl_m <= 1'b1;
        hw();
        sda_m <= 1'b1;
        hw();
    endtask
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ai, ao);
    endtask
endmodule
`default_nettype wire

// ---- tws_slave_transmitter_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tws_slave_transmitter_tb;
    localparam logic [11:0] OA = tws_pkg::ADDR_OWN_SLAVE_ADDRESS;
    localparam logic [11:0] CT = tws_pkg::ADDR_TWO_WIRE_CONTROL;
    localparam logic [11:0] DA = tws_pkg::ADDR_SHIFT_DATA;
    localparam logic [11:0] SL = tws_pkg::ADDR_SLEEP_CONTROL;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic arbitration_lost = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe, start_pending, wake_up;
    logic scl_m, sda_m;
    wire logic scl;
    wire logic sda;
    int miscompares = 0;
    int comparisons = 0;
    assign scl = scl_m & (scl_oe ? scl_out : 1'b1);
    assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
    always #10 hclk = ~hclk;
    tws_slave_transmitter u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .arbitration_lost(arbitration_lost), .start_pending(start_pending), .wake_up(wake_up));
    tws_master_model u_mst (.hclk(hclk), .scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 8'h00, r);
        chk(r, {24'h00_0000, e});
    endtask
    task automatic st(input logic [7:0] e);
        logic [31:0] r;
        ahb(1'b0, tws_pkg::ADDR_BUS_STATUS, 8'h00, r);
        chk(r & 32'h0000_00F8, {24'h00_0000, e});
    endtask
    task automatic addr(input logic [7:0] a, input logic e);
        logic [7:0] q;
        logic k;
        u_mst.start();
        u_mst.xfer(a, 1'b1, q, k);
        chk(32'(k), 32'(e));
    endtask
    task automatic rdb(input logic ma, input logic [7:0] e);
        logic [7:0] q;
        logic k;
        u_mst.xfer(8'hFF, ma, q, k);
        chk(32'(q), 32'(e));
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        st(8'hF8);
        rd(DA, 8'hFF);
        rd(12'h014, 8'h00);
        wr(OA, 8'hA5);
        wr(CT, 8'h04);
        addr(8'hA5, 1'b1);
        u_mst.stop();
        wr(CT, 8'h44);
        addr(8'hA7, 1'b1);
        u_mst.stop();
        wr(SL, 8'h01);
        addr(8'hA5, 1'b0);
        chk(32'(wake_up), 32'h0000_0001);
        chk(32'(scl_oe), 32'h0000_0001);
        st(8'hA8);
        wr(SL, 8'h00);
        wr(DA, 8'h96);
        wr(CT, 8'hC4);
        @(posedge hclk);
        chk(32'(wake_up), 32'h0000_0000);
        rdb(1'b0, 8'h96);
        chk(32'(scl_oe), 32'h0000_0001);
        st(8'hB8);
        wr(DA, 8'h3C);
        wr(CT, 8'h84);
        rdb(1'b1, 8'h3C);
        st(8'hC0);
        wr(CT, 8'hA4);
        @(posedge hclk);
        chk(32'(start_pending), 32'h0000_0001);
        u_mst.stop();
        chk(32'(start_pending), 32'h0000_0000);
        addr(8'hA5, 1'b1);
        u_mst.stop();
        wr(CT, 8'h44);
        addr(8'hA5, 1'b0);
        wr(DA, 8'h5A);
        wr(CT, 8'h84);
        rdb(1'b0, 8'h5A);
        st(8'hC8);
        wr(CT, 8'hC4);
        rdb(1'b1, 8'hFF);
        u_mst.stop();
        addr(8'h00, 1'b0);
        st(8'h70);
        wr(CT, 8'hC4);
        u_mst.stop();
        wr(OA, 8'hA4);
        addr(8'h00, 1'b1);
        u_mst.stop();
        arbitration_lost <= 1'b1;
        @(posedge hclk);
        arbitration_lost <= 1'b0;
        addr(8'hA5, 1'b0);
        st(8'hB0);
        wr(DA, 8'hC3);
        wr(CT, 8'h84);
        rdb(1'b1, 8'hC3);
        wr(CT, 8'hC4);
        u_mst.stop();
        st(8'hF8);
        summarize();
    end
    // The whole run needs some four thousand cycles; a hung stretch trips this.
    initial begin
        repeat (60000) @(posedge hclk);
        miscompares++;
        summarize();
    end
endmodule
bind tws_slave_transmitter tws_slave_transmitter_properties u_chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe), .start_pending(start_pending),
    .wake_up(wake_up));
`default_nettype wire
